// file: verilog/crs_pkg.sv
package crs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] CRS_CMD_OFF      = 8'h00;
    localparam logic [7:0] CRS_ACC_OFF      = 8'h04;
    localparam logic [7:0] CRS_STATUS_OFF   = 8'h08;
    localparam logic [7:0] CRS_PC_OFF       = 8'h0c;
    localparam logic [7:0] CRS_TOS_OFF      = 8'h10;
    localparam logic [7:0] CRS_FADDR_OFF    = 8'h14;
    localparam logic [7:0] CRS_FDATA_OFF    = 8'h18;
    localparam logic [7:0] CRS_WDOG_OFF     = 8'h1c;
    localparam logic [7:0] CRS_ENGINE_OFF   = 8'h20;

    ////////////////////////////////////////////////////////////////////////////////
    // Command word fields
    localparam int CRS_CMD_OP_LSB   = 0;
    localparam int CRS_CMD_DEST_BIT = 4;
    localparam int CRS_CMD_FA_LSB   = 8;
    localparam int CRS_CMD_LIT_LSB  = 16;

    // Status bit positions
    localparam int CRS_ST_C  = 0;
    localparam int CRS_ST_DC = 1;
    localparam int CRS_ST_Z  = 2;
    localparam int CRS_ST_PD = 3;
    localparam int CRS_ST_TO = 4;

    // Engine register bit positions
    localparam int CRS_EN_BUSY  = 0;
    localparam int CRS_EN_SLEEP = 1;

    // Watchdog register fields
    localparam int CRS_WD_PRE_LSB = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and reset values
    localparam int          CRS_PC_W        = 13;
    localparam int          CRS_FA_W        = 7;
    localparam int          CRS_SP_W        = 3;
    localparam int          CRS_SP_LSB      = 16;
    localparam logic [4:0]  CRS_STATUS_RST  = 5'h18;
    localparam logic [7:0]  CRS_ACC_RST     = 8'h00;
    localparam logic [7:0]  CRS_WDOG_CLR    = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Operation codes
    typedef enum logic [3:0] {
        CRS_OP_RETURN = 4'h0,
        CRS_OP_RLC    = 4'h1,
        CRS_OP_RRC    = 4'h2,
        CRS_OP_LSUB   = 4'h3,
        CRS_OP_FSUB   = 4'h4,
        CRS_OP_NSWAP  = 4'h5,
        CRS_OP_HALT   = 4'h6
    } crs_op_e;

    // Engine states, one-hot
    typedef enum logic [2:0] {
        CRS_S_IDLE = 3'b001,
        CRS_S_EXEC = 3'b010,
        CRS_S_RET2 = 3'b100
    } crs_state_e;

endpackage

// file: verilog/crs_core.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps

// Function
// [RULE1] Return pops the stack, loads top value into counter, no flags, two cycles
// [RULE2] Destination select 0 writes accumulator, 1 writes the addressed file register
// [RULE3] Rotate left through carry: carry into bit 0, bit 7 out to carry
// [RULE4] Rotate right through carry: carry into bit 7, bit 0 out to carry
// [RULE5] Halt clears the watchdog counter and its prescaler
// [RULE6] Halt clears powerdown flag, sets watchdog expiry flag, nothing else
// [RULE7] After halt the core sleeps with the main oscillator stopped
// [RULE8] Literal minus accumulator into accumulator, updates carry, half carry, zero
// [RULE9] File minus accumulator routed by destination, updates carry, half carry, zero
// [RULE10] Nibble exchange swaps file nibbles, routed by destination, no flags
// [RULE11] Subtract carry is inverted borrow; half carry compares low nibbles likewise
// [RULE12] Subtract zero flag set exactly when the 8-bit result is zero
module crs_core
    import crs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             osc_stop
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic                 rst_meta_q;
    logic                 rstn_s;
    logic                 pready_q;
    logic [31:0]          prdata_q;
    logic                 pslverr_q;
    crs_state_e           state_q;
    logic [3:0]           op_q;
    logic                 dest_q;
    logic [CRS_FA_W-1:0]  fa_q;
    logic [7:0]           lit_q;
    logic [7:0]           acc_q;
    logic [4:0]           status_q;
    logic [CRS_PC_W-1:0]  program_counter_q;
    logic [CRS_PC_W-1:0]  stack_top_value_q;
    logic [CRS_SP_W-1:0]  sp_q;
    logic [CRS_FA_W-1:0]  win_addr_q;
    logic [7:0]           watchdog_counter_q;
    logic [7:0]           wd_prescale_q;
    logic                 asleep_q;
    logic [7:0]           file_mem [0:(1<<CRS_FA_W)-1];
    logic                 wr_acc;
    logic                 mapped;
    logic [31:0]          rd_d;
    logic [7:0]           fval;
    logic [7:0]           minuend;
    logic [8:0]           diff;
    logic [7:0]           res;
    logic                 exec_now;
    logic                 is_sub;
    logic                 is_rot;
    logic                 wr_res;
    logic                 cmd_take;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rstn_s     <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rstn_s     <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign wr_acc = psel & penable & pready_q & pwrite;
    assign cmd_take = wr_acc & (paddr == CRS_CMD_OFF) & (state_q == CRS_S_IDLE) & ~asleep_q;

    // Read mux and map check
    always_comb begin
        mapped = 1'b1;
        rd_d   = 32'h0000_0000;
        case (paddr)
            CRS_CMD_OFF:    rd_d = {8'h00, lit_q, 1'b0, fa_q, 3'h0, dest_q, op_q};
            CRS_ACC_OFF:    rd_d = {24'h00_0000, acc_q};
            CRS_STATUS_OFF: rd_d = {27'h000_0000, status_q};
            CRS_PC_OFF:     rd_d = {19'h0_0000, program_counter_q};
            CRS_TOS_OFF:    rd_d = {13'h0000, sp_q, 3'h0, stack_top_value_q};
            CRS_FADDR_OFF:  rd_d = {25'h000_0000, win_addr_q};
            CRS_FDATA_OFF:  rd_d = {24'h00_0000, file_mem[win_addr_q]};
            CRS_WDOG_OFF:   rd_d = {16'h0000, wd_prescale_q, watchdog_counter_q};
            CRS_ENGINE_OFF: rd_d = {30'h0000_0000, asleep_q, (state_q != CRS_S_IDLE)};
            default:        mapped = 1'b0;
        endcase
    end

    // No wait states: answer is prepared in the setup cycle, ready in the first access cycle
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~mapped;
            if (psel & ~penable & ~pwrite) begin
                prdata_q <= mapped ? rd_d : 32'h0000_0000;
            end
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign osc_stop = asleep_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Engine sequencing
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            state_q <= CRS_S_IDLE;
            op_q    <= 4'h0;
            dest_q  <= 1'b0;
            fa_q    <= '0;
            lit_q   <= 8'h00;
        end else begin
            case (state_q)
                CRS_S_IDLE: begin
                    if (cmd_take) begin
                        op_q    <= pwdata[CRS_CMD_OP_LSB +: 4];
                        dest_q  <= pwdata[CRS_CMD_DEST_BIT];
                        fa_q    <= pwdata[CRS_CMD_FA_LSB +: CRS_FA_W];
                        lit_q   <= pwdata[CRS_CMD_LIT_LSB +: 8];
                        state_q <= CRS_S_EXEC;
                    end
                end
                CRS_S_EXEC: begin
                    // Return spends a second cycle before the counter loads
                    state_q <= (op_q == CRS_OP_RETURN) ? CRS_S_RET2 : CRS_S_IDLE; // [RULE1]
                end
                CRS_S_RET2: state_q <= CRS_S_IDLE;
                default:    state_q <= CRS_S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath results
    assign exec_now = (state_q == CRS_S_EXEC);
    assign fval     = file_mem[fa_q];
    assign is_sub   = (op_q == CRS_OP_LSUB) | (op_q == CRS_OP_FSUB);
    assign is_rot   = (op_q == CRS_OP_RLC) | (op_q == CRS_OP_RRC);
    assign minuend  = (op_q == CRS_OP_LSUB) ? lit_q : fval; // [RULE8] [RULE9]
    assign diff     = {1'b0, minuend} - {1'b0, acc_q};

    always_comb begin
        res    = 8'h00;
        wr_res = 1'b0;
        case (op_q)
            CRS_OP_RLC: begin
                res    = {fval[6:0], status_q[CRS_ST_C]}; // [RULE3]
                wr_res = 1'b1;
            end
            CRS_OP_RRC: begin
                res    = {status_q[CRS_ST_C], fval[7:1]}; // [RULE4]
                wr_res = 1'b1;
            end
            CRS_OP_LSUB, CRS_OP_FSUB: begin
                res    = diff[7:0];
                wr_res = 1'b1;
            end
            CRS_OP_NSWAP: begin
                res    = {fval[3:0], fval[7:4]}; // [RULE10]
                wr_res = 1'b1;
            end
            default: begin
                res    = 8'h00;
                wr_res = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulator: literal subtract always lands here
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            acc_q <= CRS_ACC_RST;
        end else if (exec_now & wr_res & ((op_q == CRS_OP_LSUB) | ~dest_q)) begin
            acc_q <= res; // [RULE2] [RULE8]
        end else if (wr_acc & (paddr == CRS_ACC_OFF)) begin
            acc_q <= pwdata[7:0];
        end
    end

    // File registers; engine write has priority over the bus window
    always_ff @(posedge clk_sys) begin
        if (exec_now & wr_res & (op_q != CRS_OP_LSUB) & dest_q) begin
            file_mem[fa_q] <= res; // [RULE2] [RULE9] [RULE10]
        end else if (wr_acc & (paddr == CRS_FDATA_OFF)) begin
            file_mem[win_addr_q] <= pwdata[7:0];
        end
    end

    // Window address for the file data port
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            win_addr_q <= '0;
        end else if (wr_acc & (paddr == CRS_FADDR_OFF)) begin
            win_addr_q <= pwdata[CRS_FA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags; engine updates win over a bus write
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            status_q <= CRS_STATUS_RST;
        end else if (exec_now & is_sub) begin
            status_q[CRS_ST_C]  <= ~diff[8]; // [RULE11]
            status_q[CRS_ST_DC] <= (acc_q[3:0] <= minuend[3:0]); // [RULE11]
            status_q[CRS_ST_Z]  <= (diff[7:0] == 8'h00); // [RULE12]
        end else if (exec_now & is_rot) begin
            status_q[CRS_ST_C]  <= (op_q == CRS_OP_RLC) ? fval[7] : fval[0]; // [RULE3] [RULE4]
        end else if (exec_now & (op_q == CRS_OP_HALT)) begin
            status_q[CRS_ST_PD] <= 1'b0; // [RULE6]
            status_q[CRS_ST_TO] <= 1'b1; // [RULE6]
        end else if (wr_acc & (paddr == CRS_STATUS_OFF)) begin
            status_q <= pwdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter and stack top; return loads in its second cycle
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            program_counter_q <= '0;
            stack_top_value_q <= '0;
            sp_q              <= '0;
        end else if (state_q == CRS_S_RET2) begin
            program_counter_q <= stack_top_value_q; // [RULE1]
            sp_q              <= sp_q - 3'h1; // [RULE1]
        end else begin
            if (wr_acc & (paddr == CRS_PC_OFF)) begin
                program_counter_q <= pwdata[CRS_PC_W-1:0];
            end
            if (wr_acc & (paddr == CRS_TOS_OFF)) begin
                stack_top_value_q <= pwdata[CRS_PC_W-1:0];
                sp_q              <= pwdata[CRS_SP_LSB +: CRS_SP_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog count and prescaler images, cleared by halt
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            watchdog_counter_q <= CRS_WDOG_CLR;
            wd_prescale_q      <= CRS_WDOG_CLR;
        end else if (exec_now & (op_q == CRS_OP_HALT)) begin
            watchdog_counter_q <= CRS_WDOG_CLR; // [RULE5]
            wd_prescale_q      <= CRS_WDOG_CLR; // [RULE5]
        end else if (wr_acc & (paddr == CRS_WDOG_OFF)) begin
            watchdog_counter_q <= pwdata[7:0];
            wd_prescale_q      <= pwdata[CRS_WD_PRE_LSB +: 8];
        end
    end

    // Sleep state drives the oscillator stop; software wakes by clearing it
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            asleep_q <= 1'b0;
        end else if (exec_now & (op_q == CRS_OP_HALT)) begin
            asleep_q <= 1'b1; // [RULE7]
        end else if (wr_acc & (paddr == CRS_ENGINE_OFF) & ~pwdata[CRS_EN_SLEEP]) begin
            asleep_q <= 1'b0;
        end
    end

endmodule

// file: dv/crs_core_monitor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module crs_core_monitor
    import crs_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        osc_stop
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Halt and wake requests at the access edge
    logic halt_acc;
    logic wake_acc;
    assign halt_acc = psel && penable && pwrite && paddr == CRS_CMD_OFF && pwdata[3:0] == 4'h6;
    assign wake_acc = psel && penable && pwrite && paddr == CRS_ENGINE_OFF && !pwdata[1];
    // Bus phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (s_setup |=> s_access) else $error("no ready");
    a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_idle_quiet: assert property (!psel |=> !pready) else $error("ready while idle");
    a_err_unmapped: assert property (s_setup ##0 paddr > CRS_ENGINE_OFF |=> pslverr)
        else $error("no error");
    a_err_mapped: assert property (psel && !penable && paddr <= CRS_ENGINE_OFF
        && paddr[1:0] == 2'h0 |=> !pslverr) else $error("false error");
    a_err_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("err data");
    a_halt_sleeps: assert property ($rose(osc_stop) |-> $past(halt_acc, 2))
        else $error("sleep without halt");
    a_wake_only: assert property ($fell(osc_stop) |-> $past(wake_acc) || $past(wake_acc, 2))
        else $error("wake without write");
endmodule

bind crs_core crs_core_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .osc_stop(osc_stop));

// file: dv/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////////////
module testbench
    import crs_pkg::*;
;
    logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, osc_stop, er, dest;
    logic [7:0]  paddr, f, a, k;
    logic [31:0] pwdata, prdata, rv, r1, r2;
    logic [12:0] ex;
    int          n_fail, checks, seed;

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    crs_core uut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .osc_stop(osc_stop));

    // One bus transfer, held until ready is seen
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge clk_sys);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= ad;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1 && n < 16) begin
                @(posedge clk_sys);
                n++;
            end
            if (n == 16) n_fail++;
            rv = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Command launch, then wait for the engine to go idle
    task automatic cmd(input logic [31:0] c);
        int n;
        begin
            xfer(1'b1, CRS_CMD_OFF, c);
            n = 0;
            rv = 32'h1;
            while (rv[0] !== 1'b0 && n < 8) begin
                xfer(1'b0, CRS_ENGINE_OFF, 32'h0);
                n++;
            end
            if (n == 8) n_fail++;
        end
    endtask

    // Expected result and status of one operation
    function automatic logic [12:0] alu(input logic [3:0] op, input logic [7:0] fv, av, kv,
                                        input logic [4:0] st);
        logic [7:0] m, r;
        logic [4:0] s;
        begin
            s = st;
            r = fv;
            m = (op == CRS_OP_LSUB) ? kv : fv;
            case (op)
                CRS_OP_RLC: {s[0], r} = {fv, st[0]};
                CRS_OP_RRC: {r, s[0]} = {st[0], fv};
                CRS_OP_NSWAP: r = {fv[3:0], fv[7:4]};
                CRS_OP_LSUB, CRS_OP_FSUB: begin
                    r = m - av;
                    s[2:0] = {r == 8'h00, av[3:0] <= m[3:0], av <= m};
                end
                default: r = fv;
            endcase
            return {r, s};
        end
    endfunction

    task automatic end_of_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        #2000000;
        n_fail++;
        end_of_test;
    end

    // Main sequence
    initial begin
        {seed, n_fail, checks} = {32'd2628, 64'h0};
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        xfer(1'b0, CRS_STATUS_OFF, 32'h0);
        `CHK(rv, 32'h18)
        xfer(1'b0, 8'h40, 32'h0);
        `CHK({er, rv}, 33'h100000000)
        $display("test reset done");
        for (int i = 0; i < 40; i++) begin
            r1 = $random(seed);
            r2 = $random(seed);
            dest = r2[7];
            {k, f} = r1[23:8];
            a = (i % 8 == 0) ? ((i % 5 == 2) ? k : f) : r1[31:24];
            xfer(1'b1, CRS_ACC_OFF, {24'h0, a});
            xfer(1'b1, CRS_STATUS_OFF, {27'h0, r2[4:0]});
            xfer(1'b1, CRS_FADDR_OFF, {25'h0, r1[6:0]});
            xfer(1'b1, CRS_FDATA_OFF, {24'h0, f});
            cmd({8'h0, k, 1'b0, r1[6:0], 3'h0, dest, 4'(1 + i % 5)});
            ex = alu(4'(1 + i % 5), f, a, k, r2[4:0]);
            xfer(1'b0, CRS_ACC_OFF, 32'h0);
            `CHK(rv[7:0], (i % 5 == 2 || !dest) ? ex[12:5] : a)
            xfer(1'b0, CRS_FDATA_OFF, 32'h0);
            `CHK(rv[7:0], (i % 5 != 2 && dest) ? ex[12:5] : f)
            xfer(1'b0, CRS_STATUS_OFF, 32'h0);
            `CHK(rv[4:0], ex[4:0])
        end
        $display("test alu done");
        xfer(1'b1, CRS_TOS_OFF, {13'h0, 3'h5, 3'h0, r1[12:0]});
        xfer(1'b1, CRS_STATUS_OFF, 32'h7);
        cmd(32'h0);
        xfer(1'b0, CRS_PC_OFF, 32'h0);
        `CHK(rv, {19'h0, r1[12:0]})
        xfer(1'b0, CRS_TOS_OFF, 32'h0);
        `CHK(rv[18:16], 3'h4)
        xfer(1'b0, CRS_STATUS_OFF, 32'h0);
        `CHK(rv, 32'h7)
        $display("test return done");
        xfer(1'b1, CRS_WDOG_OFF, r2 | 32'h101);
        xfer(1'b1, CRS_STATUS_OFF, 32'hd);
        cmd(32'h6);
        `CHK(osc_stop, 1'b1)
        xfer(1'b0, CRS_WDOG_OFF, 32'h0);
        `CHK(rv[15:0], 16'h0)
        xfer(1'b0, CRS_STATUS_OFF, 32'h0);
        `CHK(rv, 32'h15)
        xfer(1'b0, CRS_ACC_OFF, 32'h0);
        r1 = rv;
        cmd(32'h5);
        xfer(1'b0, CRS_ACC_OFF, 32'h0);
        `CHK(rv, r1)
        xfer(1'b1, CRS_ENGINE_OFF, 32'h0);
        xfer(1'b0, CRS_ENGINE_OFF, 32'h0);
        `CHK(osc_stop, 1'b0)
        $display("test halt done");
        end_of_test;
    end
endmodule
